// ### hdl/usc_pkg.sv
// Register map, field layout, reset values and shared types of the UART.
package usc_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int BAUD_HZ = 115_200;
  localparam int CLKS_PER_BIT = CLK_HZ / BAUD_HZ;
  localparam int TX_DEPTH = 4;
  localparam int IRDA_NUM = 3;
  localparam int IRDA_DEN = 16;
  localparam int FRAME_BITS = 10;
  localparam int BREAK_BITS = 14;
  localparam logic [7:0] STA_OFS = 8'h00;
  localparam logic [7:0] MODE_OFS = 8'h04;
  localparam logic [7:0] TXD_OFS = 8'h08;
  localparam logic [7:0] RXD_OFS = 8'h0c;
  localparam logic [7:0] IST_OFS = 8'h10;
  localparam logic [7:0] IEN_OFS = 8'h14;
  localparam logic [7:0] ICLR_OFS = 8'h18;
  localparam int ADM_BIT = 24;
  localparam int ADDR_LSB = 16;
  localparam int TXSEL_LSB = 14;
  localparam int TXINV_BIT = 13;
  localparam int RXEN_BIT = 12;
  localparam int BRK_BIT = 11;
  localparam int TXEN_BIT = 10;
  localparam int TXBF_BIT = 9;
  localparam int TX_SHIFT_EMPTY_BIT = 8;
  localparam int RXSEL_LSB = 6;
  localparam int ADDR_CHAR_DETECT_BIT = 5;
  localparam int RX_LINE_IDLE_BIT = 4;
  localparam int PARITY_ERROR_FLAG_BIT = 3;
  localparam int FRAMING_ERROR_FLAG_BIT = 2;
  localparam int OVERRUN_ERROR_FLAG_BIT = 1;
  localparam int RX_DATA_AVAILABLE_BIT = 0;
  localparam int ON_BIT = 15;
  localparam int INFRARED_ENABLE_BIT = 12;
  localparam int PAREN_BIT = 0;
  localparam logic [1:0] TXSEL_SPACE = 2'h0;
  localparam logic [1:0] TXSEL_DONE = 2'h1;
  localparam logic [1:0] TXSEL_EMPTY = 2'h2;
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_ERR = 2;
  localparam int IRQ_BRK = 3;
  localparam int IRQ_W = 4;
  localparam logic TX_PIN_RST = 1'b1;
  localparam logic TX_OE_N_RST = 1'b1;
  typedef struct packed {
    logic full;
    logic empty;
    logic shift_empty;
  } usc_tx_stat_t;
  typedef struct packed {
    logic valid;
    logic parity_error_flag;
    logic framing_error_flag;
    logic [7:0] data;
  } usc_rx_char_t;
  typedef struct packed {
    logic adm;
    logic [7:0] addr;
    logic [1:0] txsel;
    logic txinv;
    logic rxen;
    logic brk;
    logic txen;
    logic [1:0] rxsel;
    logic addr_char_detect;
    logic overrun_error_flag;
    logic on;
    logic infrared_enable;
    logic paren;
    logic [IRQ_W-1:0] ien;
    logic [IRQ_W-1:0] ist;
    logic [7:0] rxd;
    logic rxda;
    logic parity_error_flag;
    logic framing_error_flag;
    logic matched;
  } usc_ctrl_t;
  localparam usc_ctrl_t CTRL_RST = '0;
endpackage

// ### hdl/usc_tx.sv
// Transmit buffer, shift register and break generator.
`timescale 1ns/100ps
module usc_tx #(
  parameter int CLKS_PER_BIT = usc_pkg::CLKS_PER_BIT,
  parameter int DEPTH = usc_pkg::TX_DEPTH
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic en_i,
  input wire logic push_i,
  input wire logic [7:0] din_i,
  input wire logic brk_i,
  output usc_pkg::usc_tx_stat_t stat_o,
  output logic line_o,
  output logic early_o,
  output logic brk_done_o
);
  import usc_pkg::*;
  localparam int PW = $clog2(DEPTH);
  localparam int DW = $clog2(CLKS_PER_BIT);
  localparam logic [DW-1:0] DIV_LAST = DW'(CLKS_PER_BIT - 1);
  localparam logic [DW-1:0] EARLY = DW'(CLKS_PER_BIT * IRDA_NUM / IRDA_DEN);
  typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} usc_tx_state_t;
  logic [7:0] mem [DEPTH];
  usc_tx_state_t state_reg, state_next;
  logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [PW:0] cnt_reg, cnt_next;
  logic [BREAK_BITS-1:0] sr_reg, sr_next;
  logic [3:0] nb_reg, nb_next;
  logic [DW-1:0] div_reg, div_next;
  logic brk_reg, brk_next, done_reg, done_next, push_ok, pop;

  always_comb
  begin
    state_next = state_reg;
    sr_next = sr_reg;
    nb_next = nb_reg;
    div_next = div_reg;
    brk_next = brk_reg;
    done_next = 1'b0;
    pop = 1'b0;
    push_ok = push_i && (cnt_reg != (PW+1)'(DEPTH));
    if (state_reg == TX_SHIFT)
    begin
      div_next = div_reg + 1'b1;
      if (div_reg == DIV_LAST)
      begin
        div_next = '0;
        sr_next = {1'b1, sr_reg[BREAK_BITS-1:1]};
        nb_next = nb_reg - 4'h1;
        if (nb_reg == 4'h1)
        begin
          state_next = TX_IDLE;
          done_next = brk_reg;
          brk_next = 1'b0;
        end
      end
    end
    // The done pulse blocks a second break while the request bit clears.
    else if (brk_i && !done_reg)
    begin
      state_next = TX_SHIFT;
      sr_next = {1'b1, {(BREAK_BITS-1){1'b0}}};
      nb_next = 4'(BREAK_BITS);
      brk_next = 1'b1;
    end
    else if (cnt_reg != '0)
    begin
      state_next = TX_SHIFT;
      pop = 1'b1;
      sr_next = {{(BREAK_BITS-FRAME_BITS+1){1'b1}}, mem[rp_reg], 1'b0};
      nb_next = 4'(FRAME_BITS);
    end
    wp_next = wp_reg + PW'(push_ok);
    rp_next = rp_reg + PW'(pop);
    cnt_next = cnt_reg + (PW+1)'(push_ok) - (PW+1)'(pop);
    if (!en_i)
    begin
      state_next = TX_IDLE;
      wp_next = '0;
      rp_next = '0;
      cnt_next = '0;
      div_next = '0;
      brk_next = 1'b0;
      done_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_reg <= TX_IDLE;
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      sr_reg <= '0;
      nb_reg <= '0;
      div_reg <= '0;
      brk_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      state_reg <= state_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      sr_reg <= sr_next;
      nb_reg <= nb_next;
      div_reg <= div_next;
      brk_reg <= brk_next;
      done_reg <= done_next;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i && en_i && push_ok)
      mem[wp_reg] <= din_i;
  end

  assign line_o = (state_reg == TX_SHIFT) ? sr_reg[0] : 1'b1;
  assign early_o = (div_reg < EARLY);
  assign brk_done_o = done_reg;
  assign stat_o.full = (cnt_reg == (PW+1)'(DEPTH));
  assign stat_o.empty = (cnt_reg == '0);
  assign stat_o.shift_empty = (cnt_reg == '0) && (state_reg == TX_IDLE);
endmodule

// ### hdl/usc_rx.sv
// Receive deserialiser with framing and even-parity checks.
`timescale 1ns/100ps
module usc_rx #(
  parameter int CLKS_PER_BIT = usc_pkg::CLKS_PER_BIT
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic en_i,
  input wire logic par_en_i,
  input wire logic pin_i,
  output usc_pkg::usc_rx_char_t char_o,
  output logic idle_o
);
  import usc_pkg::*;
  localparam int DW = $clog2(CLKS_PER_BIT);
  localparam logic [DW-1:0] DIV_LAST = DW'(CLKS_PER_BIT - 1);
  localparam logic [DW-1:0] HALF = DW'(CLKS_PER_BIT / 2);
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01,
    RX_DATA = 2'b10, RX_STOP = 2'b11} usc_rx_state_t;
  usc_rx_state_t state_reg, state_next;
  logic [8:0] sr_reg, sr_next;
  logic [3:0] nb_reg, nb_next;
  logic [DW-1:0] div_reg, div_next;
  usc_rx_char_t char_reg, char_next;

  always_comb
  begin
    state_next = state_reg;
    sr_next = sr_reg;
    nb_next = nb_reg;
    div_next = div_reg + 1'b1;
    char_next = char_reg;
    char_next.valid = 1'b0;
    case (state_reg)
      RX_IDLE:
      begin
        div_next = '0;
        if (!pin_i)
          state_next = RX_START;
      end
      RX_START:
        if (div_reg == HALF)
        begin
          div_next = '0;
          nb_next = '0;
          state_next = pin_i ? RX_IDLE : RX_DATA;
        end
      RX_DATA:
        if (div_reg == DIV_LAST)
        begin
          div_next = '0;
          sr_next = {pin_i, sr_reg[8:1]};
          nb_next = nb_reg + 4'h1;
          if (nb_reg == (par_en_i ? 4'h8 : 4'h7))
            state_next = RX_STOP;
        end
      default:
        if (div_reg == DIV_LAST)
        begin
          state_next = RX_IDLE;
          char_next.valid = 1'b1;
          char_next.framing_error_flag = !pin_i;
          char_next.parity_error_flag = par_en_i && (^sr_reg);
          char_next.data = par_en_i ? sr_reg[7:0] : sr_reg[8:1];
        end
    endcase
    if (!en_i)
    begin
      state_next = RX_IDLE;
      char_next.valid = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_reg <= RX_IDLE;
      sr_reg <= '0;
      nb_reg <= '0;
      div_reg <= '0;
      char_reg <= '0;
    end
    else if (ce_i)
    begin
      state_reg <= state_next;
      sr_reg <= sr_next;
      nb_reg <= nb_next;
      div_reg <= div_next;
      char_reg <= char_next;
    end
  end

  assign char_o = char_reg;
  assign idle_o = (state_reg == RX_IDLE);
endmodule

// ### hdl/usc_top.sv
// UART status and control register block with APB access and pin logic.
`timescale 1ns/100ps
module usc_top #(
  parameter int CLKS_PER_BIT = usc_pkg::CLKS_PER_BIT,
  parameter int TX_DEPTH = usc_pkg::TX_DEPTH
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rx_pin_i,
  output logic tx_pin_o,
  output logic tx_pin_oe_n_o,
  output logic rx_pin_own_o,
  output logic irq_o
);
  import usc_pkg::*;

  usc_ctrl_t ctrl_reg, ctrl_next;
  usc_tx_stat_t tx_stat;
  usc_rx_char_t rx_char;
  logic [31:0] prdata_reg, prdata_next, rd_word, sta_word;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic tx_pin_reg, tx_pin_next, tx_oe_n_reg, tx_oe_n_next;
  logic rx_own_reg, rx_own_next, irq_reg, irq_next;
  logic access, first, wr_done, rd_done, mapped;
  logic tx_run, rx_run, tx_push, tx_line, tx_early, brk_done, rx_idle;
  logic tx_cond, rx_ev, err_ev, rd_rxd;
  logic [IRQ_W-1:0] ev;

  assign tx_run = ctrl_reg.on && ctrl_reg.txen;
  assign rx_run = ctrl_reg.on && ctrl_reg.rxen;

  // APB handshake: with ce_i high the access phase lasts two cycles, so a write
  // commits and read side effects occur only at the edge that ends it.
  assign access = psel_i && penable_i;
  assign first = access && !pready_reg;
  assign wr_done = access && pready_reg && pwrite_i;
  assign rd_done = access && pready_reg && !pwrite_i;
  assign rd_rxd = rd_done && (paddr_i == RXD_OFS);

  always_comb
  begin
    sta_word = '0;
    sta_word[ADM_BIT] = ctrl_reg.adm;
    sta_word[ADDR_LSB +: 8] = ctrl_reg.addr;
    sta_word[TXSEL_LSB +: 2] = ctrl_reg.txsel;
    sta_word[TXINV_BIT] = ctrl_reg.txinv;
    sta_word[RXEN_BIT] = ctrl_reg.rxen;
    sta_word[BRK_BIT] = ctrl_reg.brk;
    sta_word[TXEN_BIT] = ctrl_reg.txen;
    sta_word[TXBF_BIT] = tx_stat.full;
    sta_word[TX_SHIFT_EMPTY_BIT] = tx_stat.shift_empty;
    sta_word[RXSEL_LSB +: 2] = ctrl_reg.rxsel;
    sta_word[ADDR_CHAR_DETECT_BIT] = ctrl_reg.addr_char_detect;
    sta_word[RX_LINE_IDLE_BIT] = rx_idle;
    sta_word[PARITY_ERROR_FLAG_BIT] = ctrl_reg.parity_error_flag;
    sta_word[FRAMING_ERROR_FLAG_BIT] = ctrl_reg.framing_error_flag;
    sta_word[OVERRUN_ERROR_FLAG_BIT] = ctrl_reg.overrun_error_flag;
    sta_word[RX_DATA_AVAILABLE_BIT] = ctrl_reg.rxda;
  end

  always_comb
  begin
    mapped = 1'b1;
    rd_word = '0;
    if (paddr_i == STA_OFS)
      rd_word = sta_word;
    else if (paddr_i == MODE_OFS)
    begin
      rd_word[ON_BIT] = ctrl_reg.on;
      rd_word[INFRARED_ENABLE_BIT] = ctrl_reg.infrared_enable;
      rd_word[PAREN_BIT] = ctrl_reg.paren;
    end
    else if (paddr_i == TXD_OFS)
      rd_word = '0;
    else if (paddr_i == RXD_OFS)
      rd_word[7:0] = ctrl_reg.rxd;
    else if (paddr_i == IST_OFS)
      rd_word[IRQ_W-1:0] = ctrl_reg.ist;
    else if (paddr_i == IEN_OFS)
      rd_word[IRQ_W-1:0] = ctrl_reg.ien;
    else if (paddr_i == ICLR_OFS)
      rd_word = '0;
    else
      mapped = 1'b0;
  end

  always_comb
  begin
    pready_next = first;
    pslverr_next = first && !mapped;
    prdata_next = (first && !pwrite_i) ? rd_word : '0;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end
    else if (ce_i)
    begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  always_comb
  begin
    ctrl_next = ctrl_reg;
    tx_push = wr_done && (paddr_i == TXD_OFS) && tx_run;
    rx_ev = 1'b0;
    err_ev = 1'b0;
    if (wr_done)
    begin
      if (paddr_i == STA_OFS)
      begin
        ctrl_next.adm = pwdata_i[ADM_BIT];
        ctrl_next.addr = pwdata_i[ADDR_LSB +: 8];
        ctrl_next.txsel = pwdata_i[TXSEL_LSB +: 2];
        ctrl_next.txinv = pwdata_i[TXINV_BIT];
        ctrl_next.rxen = pwdata_i[RXEN_BIT];
        ctrl_next.brk = pwdata_i[BRK_BIT];
        ctrl_next.txen = pwdata_i[TXEN_BIT];
        ctrl_next.rxsel = pwdata_i[RXSEL_LSB +: 2];
        ctrl_next.addr_char_detect = pwdata_i[ADDR_CHAR_DETECT_BIT];
        if (!pwdata_i[OVERRUN_ERROR_FLAG_BIT])
          ctrl_next.overrun_error_flag = 1'b0;
      end
      else if (paddr_i == MODE_OFS)
      begin
        ctrl_next.on = pwdata_i[ON_BIT];
        ctrl_next.infrared_enable = pwdata_i[INFRARED_ENABLE_BIT];
        ctrl_next.paren = pwdata_i[PAREN_BIT];
      end
      else if (paddr_i == IEN_OFS)
        ctrl_next.ien = pwdata_i[IRQ_W-1:0];
      else if (paddr_i == ICLR_OFS)
        ctrl_next.ist = ctrl_reg.ist & ~pwdata_i[IRQ_W-1:0];
    end
    // Hardware completion wins over a stale read-modify-write of the bit.
    if (brk_done)
      ctrl_next.brk = 1'b0;
    if (rd_rxd)
    begin
      ctrl_next.rxda = 1'b0;
      ctrl_next.parity_error_flag = 1'b0;
      ctrl_next.framing_error_flag = 1'b0;
    end
    if (!ctrl_next.adm)
      ctrl_next.matched = 1'b0;
    if (rx_char.valid)
    begin
      if (ctrl_reg.adm && !ctrl_reg.matched)
      begin
        // The address character itself is consumed, not delivered.
        if (rx_char.data == ctrl_reg.addr)
          ctrl_next.matched = 1'b1;
      end
      else if (ctrl_next.rxda)
      begin
        ctrl_next.overrun_error_flag = 1'b1;
        err_ev = 1'b1;
      end
      else
      begin
        ctrl_next.rxd = rx_char.data;
        ctrl_next.rxda = 1'b1;
        ctrl_next.parity_error_flag = rx_char.parity_error_flag;
        ctrl_next.framing_error_flag = rx_char.framing_error_flag;
        rx_ev = 1'b1;
        err_ev = rx_char.parity_error_flag || rx_char.framing_error_flag;
      end
    end
    case (ctrl_reg.txsel)
      TXSEL_SPACE: tx_cond = !tx_stat.full;
      TXSEL_DONE: tx_cond = tx_stat.shift_empty;
      TXSEL_EMPTY: tx_cond = tx_stat.empty;
      default: tx_cond = 1'b0;
    endcase
    ev = '0;
    ev[IRQ_TX] = tx_cond && tx_run;
    ev[IRQ_RX] = rx_ev;
    ev[IRQ_ERR] = err_ev;
    ev[IRQ_BRK] = brk_done;
    // Setting after the clear keeps an event that lands on a clear.
    ctrl_next.ist = ctrl_next.ist | ev;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ctrl_reg <= CTRL_RST;
    else if (ce_i)
      ctrl_reg <= ctrl_next;
  end

  // The infrared pulse is a short high during the first part of a zero
  // bit; the invert bit then flips the whole encoded stream.
  always_comb
  begin
    if (ctrl_reg.infrared_enable)
      tx_pin_next = (!tx_line && tx_early) ^ ctrl_reg.txinv;
    else
      tx_pin_next = tx_line ^ ctrl_reg.txinv;
    tx_oe_n_next = !tx_run;
    rx_own_next = rx_run;
    irq_next = |(ctrl_next.ist & ctrl_next.ien);
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tx_pin_reg <= TX_PIN_RST;
      tx_oe_n_reg <= TX_OE_N_RST;
      rx_own_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      tx_pin_reg <= tx_pin_next;
      tx_oe_n_reg <= tx_oe_n_next;
      rx_own_reg <= rx_own_next;
      irq_reg <= irq_next;
    end
  end

  usc_tx #(
    .CLKS_PER_BIT(CLKS_PER_BIT),
    .DEPTH(TX_DEPTH)
  ) u_tx (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .en_i(tx_run),
    .push_i(tx_push),
    .din_i(pwdata_i[7:0]),
    .brk_i(ctrl_reg.brk),
    .stat_o(tx_stat),
    .line_o(tx_line),
    .early_o(tx_early),
    .brk_done_o(brk_done)
  );

  // A disabled receiver sees a constant idle line, so the pin is ignored.
  usc_rx #(
    .CLKS_PER_BIT(CLKS_PER_BIT)
  ) u_rx (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .en_i(rx_run),
    .par_en_i(ctrl_reg.paren),
    .pin_i(rx_run ? rx_pin_i : 1'b1),
    .char_o(rx_char),
    .idle_o(rx_idle)
  );

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign tx_pin_o = tx_pin_reg;
  assign tx_pin_oe_n_o = tx_oe_n_reg;
  assign rx_pin_own_o = rx_own_reg;
  assign irq_o = irq_reg;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_reserved_zero: assert property (
    pready_o && psel_i && !pwrite_i && paddr_i == STA_OFS
    |-> prdata_o[31:25] == 7'h0)
    else $error("reserved status bits read nonzero");

  a_full_flag: assert property (
    tx_stat.full |-> !tx_stat.empty && !tx_stat.shift_empty)
    else $error("full buffer reported empty");

  a_shift_empty: assert property (
    tx_stat.shift_empty |-> tx_line && tx_stat.empty)
    else $error("shift empty while frame or data pending");

  a_tx_abort: assert property (
    ce_i && !tx_run |=> tx_stat.empty && tx_stat.shift_empty)
    else $error("transmit disable did not reset buffer");

  a_tx_pin_own: assert property (
    ce_i |=> tx_pin_oe_n_o == !$past(tx_run))
    else $error("transmit pin ownership wrong");

  a_rx_pin_own: assert property (
    ce_i |=> rx_pin_own_o == $past(rx_run))
    else $error("receive pin ownership wrong");

  a_idle_plain: assert property (
    ce_i && !ctrl_reg.infrared_enable && tx_stat.shift_empty
    |=> tx_pin_o == !$past(ctrl_reg.txinv))
    else $error("plain idle level wrong");

  a_idle_irda: assert property (
    ce_i && ctrl_reg.infrared_enable && tx_stat.shift_empty
    |=> tx_pin_o == $past(ctrl_reg.txinv))
    else $error("infrared idle level wrong");

  a_txirq_empty: assert property (
    ce_i && tx_run && ctrl_reg.txsel == TXSEL_EMPTY && tx_stat.empty
    |=> ctrl_reg.ist[IRQ_TX])
    else $error("empty-buffer interrupt missing");

  a_txirq_done: assert property (
    ce_i && tx_run && ctrl_reg.txsel == TXSEL_DONE && tx_stat.shift_empty
    |=> ctrl_reg.ist[IRQ_TX])
    else $error("all-sent interrupt missing");

  a_txirq_space: assert property (
    ce_i && tx_run && ctrl_reg.txsel == TXSEL_SPACE && !tx_stat.full
    |=> ctrl_reg.ist[IRQ_TX])
    else $error("buffer-space interrupt missing");

  a_break_clear: assert property (
    ce_i && brk_done |=> !ctrl_reg.brk)
    else $error("break request not cleared");

  a_addr_filter: assert property (
    ce_i && rx_char.valid && ctrl_reg.adm && !ctrl_reg.matched
    && !ctrl_reg.rxda |=> !ctrl_reg.rxda)
    else $error("character delivered before address match");

  a_overrun_set: assert property (
    ce_i && rx_char.valid && ctrl_reg.rxda && !rd_rxd
    && !(ctrl_reg.adm && !ctrl_reg.matched) |=> ctrl_reg.overrun_error_flag)
    else $error("overrun not flagged");

  a_apb_ready: assert property (
    ce_i && psel_i && penable_i && !pready_o |=> pready_o)
    else $error("access not answered in one cycle");

  c_break_done: cover property (ce_i && brk_done);
  c_addr_match: cover property (ce_i && $rose(ctrl_reg.matched));
  c_overrun: cover property (ce_i && $rose(ctrl_reg.overrun_error_flag));
  c_irq: cover property ($rose(irq_o));
endmodule

// ### testbench/usc_partner.sv
// Remote serial transceiver model facing the transmit and receive pins.
`timescale 1ns/100ps
module usc_partner #(
  parameter int CPB = 8
) (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  int got[$];
  int lows[$];
  int low_run = 0;
  logic [7:0] sh;
  initial line_o = 1'h1;
  // The line idles high; a frame is start low, 8 bits LSB first, stop high.
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++)
    begin
      line_o <= f[i];
      repeat (CPB) @(posedge clk_i);
    end
  endtask
  // Low runs are kept so that a break can be timed.
  always @(posedge clk_i)
  begin
    low_run <= line_i ? 0 : low_run + 1;
    if (line_i && low_run != 0)
      lows.push_back(low_run);
  end
  // Bits are taken mid-cell, away from the edges where they change.
  initial forever
  begin
    @(negedge line_i);
    repeat (CPB / 2 + CPB) @(posedge clk_i);
    for (int i = 0; i < 8; i++)
    begin
      sh[i] = line_i;
      repeat (CPB) @(posedge clk_i);
    end
    got.push_back(sh);
  end
endmodule

// ### testbench/tb_usc_top.sv
// Self-checking testbench of the UART status and control block.
`timescale 1ns/100ps
module tb_usc_top;
  import usc_pkg::*;
  localparam int CPB = 8;
  logic clk_i = 1'h0;
  logic rstn_i = 1'h0;
  logic ce_i = 1'h1;
  logic psel_i = 1'h0;
  logic penable_i = 1'h0;
  logic pwrite_i = 1'h0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic rx_pin;
  logic tx_pin_o;
  logic tx_pin_oe_n_o;
  logic rx_pin_own_o;
  logic irq_o;
  int errors = 0;
  int comparisons = 0;
  int txq[$];
  logic [31:0] rd;
  logic err;
  logic [7:0] b;
  always #4 clk_i = ~clk_i;
  usc_top #(.CLKS_PER_BIT(CPB)) usc_top_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rx_pin_i(rx_pin), .tx_pin_o(tx_pin_o),
    .tx_pin_oe_n_o(tx_pin_oe_n_o), .rx_pin_own_o(rx_pin_own_o),
    .irq_o(irq_o));
  usc_partner #(.CPB(CPB)) usc_partner_i (
    .clk_i(clk_i), .line_i(tx_pin_o), .line_o(rx_pin));
  task automatic give_verdict;
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Ready is sampled at each rising edge; the request stands until the edge
  // that shows it high, and one idle edge follows the release.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'h1 && n < 50);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    if (n >= 50)
    begin
      errors++;
      give_verdict();
    end
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic poll(input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    do
    begin
      apb(1'h0, STA_OFS, 32'h0);
      n++;
    end while ((rd & m) !== e && n < 400);
    chk(rd & m, e);
    if ((rd & m) !== e)
      give_verdict();
  endtask
  initial
  begin
    void'($urandom(32'h85d3));
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'h1;
    @(posedge clk_i);
    rdc(STA_OFS, 32'hfffffce0, 32'h0);
    apb(1'h0, 8'h40, 32'h0);
    chk({rd[31:1], err}, 32'h1);
    apb(1'h1, STA_OFS, 32'hffa59440);
    rdc(STA_OFS, 32'hfffffce0, 32'h01a59440);
    chk({31'h0, rx_pin_own_o}, 32'h0);
    apb(1'h1, MODE_OFS, 32'h8000);
    repeat (2) @(posedge clk_i);
    chk({30'h0, rx_pin_own_o, tx_pin_oe_n_o}, 32'h2);
    b = 8'($urandom);
    usc_partner_i.send(8'h11);
    usc_partner_i.send(8'ha5);
    usc_partner_i.send(b);
    repeat (3) @(posedge clk_i);
    rdc(RXD_OFS, 32'hff, {24'h0, b});
    usc_partner_i.send(8'h3c);
    usc_partner_i.send(8'hc3);
    repeat (3) @(posedge clk_i);
    rdc(STA_OFS, 32'h3, 32'h3);
    apb(1'h1, STA_OFS, 32'h00a55400);
    rdc(STA_OFS, 32'h2, 32'h0);
    rdc(RXD_OFS, 32'hff, 32'h3c);
    usc_partner_i.send(8'ha5);
    repeat (3) @(posedge clk_i);
    rdc(RXD_OFS, 32'hff, 32'ha5);
    // With parity on, the partner's stop bit is taken as the parity bit.
    apb(1'h1, MODE_OFS, 32'h8001);
    usc_partner_i.send(8'h03);
    repeat (12) @(posedge clk_i);
    rdc(STA_OFS, 32'hd, 32'h9);
    rdc(RXD_OFS, 32'hff, 32'h03);
    apb(1'h1, IEN_OFS, 32'h1);
    usc_partner_i.got.delete();
    for (int i = 0; i < 5; i++)
    begin
      b = 8'($urandom);
      txq.push_back(b);
      apb(1'h1, TXD_OFS, {24'h0, b});
    end
    rdc(STA_OFS, 32'h300, 32'h200);
    apb(1'h1, ICLR_OFS, 32'hf);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    poll(32'h300, 32'h100);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    chk(usc_partner_i.got.size(), 5);
    foreach (txq[i])
      chk(usc_partner_i.got[i], txq[i]);
    for (int c = 0; c < 3; c += 2)
    begin
      apb(1'h1, STA_OFS, 32'h0400 | (c << TXSEL_LSB));
      apb(1'h1, TXD_OFS, 32'h55);
      apb(1'h1, TXD_OFS, 32'haa);
      apb(1'h1, ICLR_OFS, 32'hf);
      repeat (2) @(posedge clk_i);
      chk({31'h0, irq_o}, c == 0);
      poll(32'h100, 32'h100);
    end
    usc_partner_i.lows.delete();
    apb(1'h1, STA_OFS, 32'h0c00);
    poll(32'h900, 32'h100);
    chk(usc_partner_i.lows[0], 13 * CPB);
    for (int i = 0; i < 3; i++)
      apb(1'h1, TXD_OFS, 32'h0f);
    apb(1'h1, STA_OFS, 32'h0);
    repeat (2) @(posedge clk_i);
    chk({31'h0, tx_pin_oe_n_o}, 32'h1);
    apb(1'h1, STA_OFS, 32'h0400);
    rdc(STA_OFS, 32'h300, 32'h100);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'h1, MODE_OFS, 32'h8000 | (i[1] << INFRARED_ENABLE_BIT));
      apb(1'h1, STA_OFS, 32'h0400 | (i[0] << TXINV_BIT));
      repeat (3) @(posedge clk_i);
      chk({31'h0, tx_pin_o}, {31'h0, ~(i[0] ^ i[1])});
    end
    // A low clock enable must hold a pending access and both transmit pins.
    fork
      apb(1'h1, MODE_OFS, 32'h0);
      begin
        ce_i <= 1'h0;
        repeat (6) @(posedge clk_i);
        chk({pready_o, tx_pin_oe_n_o, tx_pin_o}, 32'h1);
        ce_i <= 1'h1;
      end
    join
    repeat (2) @(posedge clk_i);
    chk({30'h0, rx_pin_own_o, tx_pin_oe_n_o}, 32'h1);
    give_verdict();
  end
endmodule
